// File: rtl/qwd_pkg.sv
package qwd_pkg;

    // one channel's setting: buffer mode above the eight wiper bits
    typedef struct packed {
        logic buf_mode;
        logic [7:0] wiper;
    } qwd_setting_t;

    // command decode and access machine, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } qwd_state_t;

    // core (clk domain) state
    typedef struct packed {
        logic [2:0] tog_sy;
        logic [1:0] wp_sy;
        qwd_state_t fsm;
        logic asleep;
        logic [15:0] busy_cnt;
        qwd_setting_t [3:0] wiper;
        qwd_setting_t [15:0] slot;
        logic [23:0] reply;
    } qwd_core_t;

    // link (serial clock) state, cleared between frames
    typedef struct packed {
        logic [4:0] bit_cnt;
        logic [22:0] shift;
    } qwd_link_t;

    // completed frame handed to the core
    typedef struct packed {
        logic tog;
        logic [23:0] word;
    } qwd_frame_t;

    // opcodes
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_WAKE = 4'h1;
    localparam logic [3:0] OP_PROG = 4'h2;
    localparam logic [3:0] OP_SAVE = 4'h3;
    localparam logic [3:0] OP_WRITE = 4'h4;
    localparam logic [3:0] OP_UP = 4'h7;
    localparam logic [3:0] OP_SLEEP = 4'h8;
    localparam logic [3:0] OP_RESET = 4'h9;
    localparam logic [3:0] OP_RDSLOT = 4'hA;
    localparam logic [3:0] OP_LOAD = 4'hB;
    localparam logic [3:0] OP_RDWIPER = 4'hC;
    localparam logic [3:0] OP_ERASE = 4'hD;
    localparam logic [3:0] OP_DOWN = 4'hF;

    // frame layout
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] LAST_BIT = 5'h17;
    localparam int FLD_OP_LO = 20;
    localparam int FLD_SLOT_LO = 18;
    localparam int FLD_CH_LO = 16;
    localparam int FLD_DATA_LO = 0;

    // reset and erase values, step limits
    localparam logic [8:0] SLOT_INIT = 9'h080;
    localparam logic [8:0] SLOT_ERASED = 9'h000;
    localparam logic [7:0] WIPER_TOP = 8'hFF;
    localparam logic [7:0] WIPER_BOT = 8'h00;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_ACCESS_NS = 200;
    localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_SAVE_MS = 2;
    localparam int SAVE_CYC = T_SAVE_MS * 1000000 / CLK_PERIOD_NS;

endpackage

// File: rtl/qwd_decoder.sv
`timescale 1ns/1ns
// Overview of operation
// - opcode zero changes nothing but the reply echo
// - opcode 0100 writes data byte to wiper
// - opcode 0111 raises selected wiper one step
// - opcode 1111 lowers selected wiper one step
// - steps saturate at top and bottom
// - read wiper returns wiper plus buffer mode
// - read slot returns addressed nine-bit slot
// - program slot stores buffer bit and wiper
// - save copies current setting into slot
// - opcode 1011 restores slot into wiper
// - buffer mode changes only on restore or reset
// - erase clears the addressed slot
// - slots hold nine bits, four per channel
// - channel bits pick channel, slot bits slot
// - opcode 1000 puts device to sleep
// - asleep after power, reset, sleep command
// - asleep ignores all but wake 0001
// - opcode 1001 returns to power-up state
// - power commands act on all channels
// - sample input rising, drive output falling
// - busy low after commands 2,3,A,B,C
// - msb first: opcode, slot, channel, data
// - reset loads slot zero into wipers
// - write protect low blocks erase, program
module qwd_decoder #(
    parameter int SAVE_CYCLES = qwd_pkg::SAVE_CYC
) (
    // system
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    // control pins
    input wire logic wp_n,
    output logic rdy_busy,
    // wiper settings and power state
    output qwd_pkg::qwd_setting_t [3:0] wiper_setting,
    output logic sleeping
);
    import qwd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sy_ff;
    logic rst_core_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sy_ff <= 2'h0;
        end else begin
            rst_sy_ff <= {rst_sy_ff[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sy_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // link side, clocked by the host's serial clock
    // count and shift clear with chip select, so a short frame never leaks
    qwd_link_t link_ff;
    qwd_link_t nxt_link;
    qwd_frame_t frame_ff;
    qwd_frame_t nxt_frame;
    logic [4:0] out_cnt_ff;
    logic link_rst_n;
    logic [4:0] out_idx;
    qwd_core_t c_ff;

    assign link_rst_n = rst_core_n & ~cs_n;

    always_comb begin
        nxt_link = link_ff;
        nxt_frame = frame_ff;
        if (link_ff.bit_cnt < 5'(FRAME_BITS)) begin
            nxt_link.shift = {link_ff.shift[21:0], sdi};
            nxt_link.bit_cnt = link_ff.bit_cnt + 5'h01;
        end
        // extra clocks past 24 are ignored
        if (link_ff.bit_cnt == LAST_BIT) begin
            nxt_frame.word = {link_ff.shift, sdi};
            nxt_frame.tog = ~frame_ff.tog;
        end
    end

    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_ff <= '0;
        end else begin
            link_ff <= nxt_link;
        end
    end

    always_ff @(posedge sclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            frame_ff <= '0;
        end else begin
            frame_ff <= nxt_frame;
        end
    end

    // output bit index advances on falling edges
    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            out_cnt_ff <= 5'h00;
        end else begin
            out_cnt_ff <= link_ff.bit_cnt;
        end
    end

    // reply is only rewritten in the gap after a frame, so it is stable
    // for the whole of the following frame
    assign out_idx = LAST_BIT - out_cnt_ff;
    assign sdo = (!cs_n && out_cnt_ff <= LAST_BIT) ? c_ff.reply[out_idx] : 1'b0;
    assign sdo_oe_n = cs_n;

    ////////////////////////////////////////////////////////////////////////////
    // core side
    qwd_core_t nxt_c;
    logic ev;
    logic wp_ok;
    logic exec;
    logic [3:0] op;
    logic [1:0] ch;
    logic [3:0] si;

    // the first sync stage is read only by the second
    assign ev = c_ff.tog_sy[1] ^ c_ff.tog_sy[2];
    assign wp_ok = c_ff.wp_sy[1];
    assign op = frame_ff.word[FLD_OP_LO +: 4];
    assign ch = frame_ff.word[FLD_CH_LO +: 2];
    assign si = {ch, frame_ff.word[FLD_SLOT_LO +: 2]};
    assign exec = ev && c_ff.fsm == ST_IDLE && !c_ff.asleep;

    always_comb begin
        nxt_c = c_ff;
        nxt_c.tog_sy = {c_ff.tog_sy[1:0], frame_ff.tog};
        nxt_c.wp_sy = {c_ff.wp_sy[0], wp_n};
        if (ev) begin
            nxt_c.reply = frame_ff.word;
        end
        unique case (c_ff.fsm)
            ST_IDLE: begin
                if (ev && c_ff.asleep) begin
                    if (op == OP_WAKE) begin
                        nxt_c.asleep = 1'b0;
                    end
                end else if (ev) begin
                    unique case (op)
                        OP_NOP, OP_WAKE: begin
                        end
                        OP_WRITE: begin
                            nxt_c.wiper[ch].wiper = frame_ff.word[FLD_DATA_LO +: 8];
                        end
                        OP_UP: begin
                            if (c_ff.wiper[ch].wiper != WIPER_TOP) begin
                                nxt_c.wiper[ch].wiper = c_ff.wiper[ch].wiper + 8'h01;
                            end
                        end
                        OP_DOWN: begin
                            if (c_ff.wiper[ch].wiper != WIPER_BOT) begin
                                nxt_c.wiper[ch].wiper = c_ff.wiper[ch].wiper - 8'h01;
                            end
                        end
                        OP_RDWIPER: begin
                            nxt_c.reply[8:0] = c_ff.wiper[ch];
                            nxt_c.fsm = ST_BUSY;
                            nxt_c.busy_cnt = 16'(ACCESS_CYC);
                        end
                        OP_RDSLOT: begin
                            nxt_c.reply[8:0] = c_ff.slot[si];
                            nxt_c.fsm = ST_BUSY;
                            nxt_c.busy_cnt = 16'(ACCESS_CYC);
                        end
                        OP_PROG: begin
                            if (wp_ok) begin
                                nxt_c.slot[si] = qwd_setting_t'(frame_ff.word[FLD_DATA_LO +: 9]);
                            end
                            nxt_c.fsm = ST_BUSY;
                            nxt_c.busy_cnt = 16'(SAVE_CYCLES);
                        end
                        OP_SAVE: begin
                            if (wp_ok) begin
                                nxt_c.slot[si] = c_ff.wiper[ch];
                            end
                            nxt_c.fsm = ST_BUSY;
                            nxt_c.busy_cnt = 16'(SAVE_CYCLES);
                        end
                        OP_LOAD: begin
                            nxt_c.wiper[ch] = c_ff.slot[si];
                            nxt_c.fsm = ST_BUSY;
                            nxt_c.busy_cnt = 16'(ACCESS_CYC);
                        end
                        OP_ERASE: begin
                            if (wp_ok) begin
                                nxt_c.slot[si] = SLOT_ERASED;
                            end
                        end
                        OP_SLEEP: begin
                            nxt_c.asleep = 1'b1;
                        end
                        OP_RESET: begin
                            nxt_c.asleep = 1'b1;
                            for (int i = 0; i < 4; i++) begin
                                nxt_c.wiper[i] = c_ff.slot[4 * i];
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            // host waits for ready, so a frame landing here is dropped
            ST_BUSY: begin
                if (c_ff.busy_cnt <= 16'h0001) begin
                    nxt_c.fsm = ST_IDLE;
                    nxt_c.busy_cnt = 16'h0000;
                end else begin
                    nxt_c.busy_cnt = c_ff.busy_cnt - 16'h0001;
                end
            end
            default: begin
                nxt_c.fsm = ST_IDLE;
            end
        endcase
    end

    // slots model non-volatile cells; reset gives them a known image
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            c_ff.tog_sy <= 3'h0;
            c_ff.wp_sy <= 2'h0;
            c_ff.fsm <= ST_IDLE;
            c_ff.asleep <= 1'b1;
            c_ff.busy_cnt <= 16'h0000;
            c_ff.wiper <= {4{SLOT_INIT}};
            c_ff.slot <= {16{SLOT_INIT}};
            c_ff.reply <= 24'h000000;
        end else begin
            c_ff <= nxt_c;
        end
    end

    assign rdy_busy = (c_ff.fsm == ST_IDLE);
    assign wiper_setting = c_ff.wiper;
    assign sleeping = c_ff.asleep;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_core_n);

    sequence s_cmd(logic [3:0] code);
        exec && op == code;
    endsequence

    sequence s_busy_access;
        !rdy_busy [*4] ##1 rdy_busy;
    endsequence

    nop_hold_a: assert property (s_cmd(OP_NOP) |=>
        c_ff.wiper == $past(c_ff.wiper) && c_ff.slot == $past(c_ff.slot))
        else $error("nop changed state");

    write_wiper_a: assert property (s_cmd(OP_WRITE) |=>
        c_ff.wiper[$past(ch)].wiper == $past(frame_ff.word[7:0]))
        else $error("wiper write wrong");

    step_up_a: assert property (s_cmd(OP_UP) ##0 c_ff.wiper[ch].wiper != WIPER_TOP |=>
        c_ff.wiper[$past(ch)].wiper == $past(c_ff.wiper[ch].wiper) + 8'h01)
        else $error("increment wrong");

    step_down_a: assert property (s_cmd(OP_DOWN) ##0 c_ff.wiper[ch].wiper != WIPER_BOT
        |=> c_ff.wiper[$past(ch)].wiper == $past(c_ff.wiper[ch].wiper) - 8'h01)
        else $error("decrement wrong");

    step_sat_a: assert property ((s_cmd(OP_UP) ##0 c_ff.wiper[ch].wiper == WIPER_TOP) or
        (s_cmd(OP_DOWN) ##0 c_ff.wiper[ch].wiper == WIPER_BOT) |=>
        c_ff.wiper == $past(c_ff.wiper))
        else $error("step wrapped");

    buf_mode_a: assert property (s_cmd(OP_WRITE) or s_cmd(OP_UP) or s_cmd(OP_DOWN) |=>
        c_ff.wiper[$past(ch)].buf_mode == $past(c_ff.wiper[ch].buf_mode))
        else $error("buffer mode altered");

    read_reply_a: assert property (s_cmd(OP_RDWIPER) |=>
        c_ff.reply[8:0] == $past(c_ff.wiper[ch]))
        else $error("read reply wrong");

    read_busy_a: assert property (s_cmd(OP_RDSLOT) |=> s_busy_access)
        else $error("busy window wrong");

    restore_a: assert property (s_cmd(OP_LOAD) |=>
        c_ff.wiper[$past(ch)] == $past(c_ff.slot[si]))
        else $error("restore wrong");

    protect_a: assert property (exec && !wp_ok |=> c_ff.slot == $past(c_ff.slot))
        else $error("protected slot changed");

    sleep_ignore_a: assert property (ev && c_ff.asleep && op != OP_WAKE |=>
        c_ff.asleep && c_ff.wiper == $past(c_ff.wiper) && c_ff.slot == $past(c_ff.slot))
        else $error("asleep command executed");

    soft_reset_a: assert property (s_cmd(OP_RESET) |=>
        c_ff.asleep && c_ff.wiper[0] == $past(c_ff.slot[0]) && c_ff.wiper[3] == $past(c_ff.slot[12]))
        else $error("soft reset wrong");

    erase_a: assert property (s_cmd(OP_ERASE) ##0 wp_ok |=>
        c_ff.slot[$past(si)] == SLOT_ERASED)
        else $error("erase failed");

    read_slot_a: assert property (s_cmd(OP_RDSLOT) |=>
        c_ff.reply[8:0] == $past(c_ff.slot[si]))
        else $error("slot read reply wrong");

    program_a: assert property (s_cmd(OP_PROG) ##0 wp_ok |=>
        c_ff.slot[$past(si)] == $past(frame_ff.word[8:0]))
        else $error("program wrong");

    save_slot_a: assert property (s_cmd(OP_SAVE) ##0 wp_ok |=>
        c_ff.slot[$past(si)] == $past(c_ff.wiper[ch]))
        else $error("save wrong");

    sleep_cmd_a: assert property (s_cmd(OP_SLEEP) |=>
        c_ff.asleep && c_ff.wiper == $past(c_ff.wiper))
        else $error("sleep command wrong");

    wake_a: assert property (ev && c_ff.asleep && op == OP_WAKE |=> !c_ff.asleep)
        else $error("wake ignored");

    echo_a: assert property (ev |=> c_ff.reply[23:9] == $past(frame_ff.word[23:9]))
        else $error("echo word wrong");

endmodule

// File: testbench/qwd_host.sv
`timescale 1ns/1ns
module qwd_host (
    // serial link
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    // flow control
    input wire logic rdy_busy
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // one frame; sclk stands still low outside frames, 64 ns period inside
    task automatic xfer(input logic [23:0] word, output logic [23:0] echo,
            output logic oe_bad, output logic tmo);
        tmo = 1'b1;
        oe_bad = 1'b0;
        for (int k = 0; k < 400; k++) begin
            if (rdy_busy === 1'b1) begin
                tmo = 1'b0;
                break;
            end
            #50;
        end
        // settle margin after ready, also covers the post-frame gap
        #500;
        cs_n = 1'b0;
        #100;
        for (int i = 23; i >= 0; i--) begin
            sdi = word[i];
            #32;
            echo[i] = sdo;
            oe_bad = oe_bad | (sdo_oe_n !== 1'b0);
            sclk = 1'b1;
            #32;
            sclk = 1'b0;
        end
        #100;
        // released line must not keep showing the last bit
        sdi = ~word[0];
        cs_n = 1'b1;
    endtask
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import qwd_pkg::*;
    logic clk;
    logic rst_n;
    logic wp_n;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    logic rdy_busy;
    qwd_setting_t [3:0] wiper_setting;
    logic sleeping;
    int fails = 0;
    int total_checks = 0;
    logic [8:0] wip [4];
    logic [8:0] slot [16];
    logic asleep;
    logic exp_busy;
    logic [23:0] reply;
    logic [3:0] spare [3] = '{4'h5, 4'h6, 4'hE};
    ////////////////////////////////////////////////////////////////////////
    // short save time keeps the run brief
    qwd_decoder #(.SAVE_CYCLES(20)) i_qwd_decoder (.clk(clk), .rst_n(rst_n),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .wp_n(wp_n), .rdy_busy(rdy_busy), .wiper_setting(wiper_setting),
        .sleeping(sleeping));
    qwd_host i_qwd_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .rdy_busy(rdy_busy));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [23:0] mk(input logic [3:0] op, input logic [1:0] s,
            input logic [1:0] ch, input logic [8:0] d);
        // ignored bits set to a pattern on purpose
        return {op, s, ch, 7'h55, d};
    endfunction
    // expected device behaviour, independent of the design
    task automatic model(input logic [23:0] w);
        logic [1:0] ch;
        logic [3:0] ix;
        ch = w[17:16];
        ix = w[19:16];
        reply = w;
        exp_busy = 1'b0;
        if (asleep) begin
            if (w[23:20] == OP_WAKE) asleep = 1'b0;
            return;
        end
        exp_busy = w[23:20] inside {OP_RDWIPER, OP_RDSLOT, OP_PROG, OP_LOAD, OP_SAVE};
        case (w[23:20])
            OP_WRITE: wip[ch][7:0] = w[7:0];
            OP_UP: if (wip[ch][7:0] != WIPER_TOP) wip[ch][7:0] = wip[ch][7:0] + 8'h01;
            OP_DOWN: if (wip[ch][7:0] != WIPER_BOT) wip[ch][7:0] = wip[ch][7:0] - 8'h01;
            OP_RDWIPER: reply[8:0] = wip[ch];
            OP_RDSLOT: reply[8:0] = slot[ix];
            OP_PROG: if (wp_n) slot[ix] = w[8:0];
            OP_SAVE: if (wp_n) slot[ix] = wip[ch];
            OP_LOAD: wip[ch] = slot[ix];
            OP_ERASE: if (wp_n) slot[ix] = SLOT_ERASED;
            OP_SLEEP: asleep = 1'b1;
            OP_RESET: begin
                asleep = 1'b1;
                for (int c = 0; c < 4; c++) wip[c] = slot[c];
            end
            default: ;
        endcase
    endtask
    task automatic cmd(input logic [23:0] w);
        logic [23:0] echo;
        logic oe_bad;
        logic tmo;
        logic saw;
        i_qwd_host.xfer(w, echo, oe_bad, tmo);
        if (tmo) begin
            fails++;
            stop_test();
        end
        check(36'(oe_bad), 36'h0);
        check(36'(echo), 36'(reply));
        model(w);
        saw = 1'b0;
        repeat (10) begin
            @(posedge clk);
            #1;
            saw = saw | (rdy_busy === 1'b0);
        end
        check(36'(saw), 36'(exp_busy));
        check(wiper_setting, {wip[3], wip[2], wip[1], wip[0]});
        check(36'(sleeping), 36'(asleep));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        asleep = 1'b1;
        reply = 24'h000000;
        foreach (wip[c]) wip[c] = SLOT_INIT;
        foreach (slot[c]) slot[c] = SLOT_INIT;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check(wiper_setting, {4{SLOT_INIT}});
        check(36'({sleeping, rdy_busy}), 36'h3);
        cmd(mk(OP_WRITE, 0, 0, 9'h033));
        cmd(mk(OP_WAKE, 0, 0, 0));
        $display("test power_up done");
        cmd(mk(OP_WRITE, 0, 1, 9'h1FF));
        cmd(mk(OP_UP, 0, 1, 0));
        cmd(mk(OP_WRITE, 3, 2, 9'h100));
        cmd(mk(OP_DOWN, 0, 2, 9'h1FF));
        cmd(mk(OP_UP, 0, 3, 0));
        cmd(mk(OP_DOWN, 0, 0, 0));
        cmd(mk(OP_NOP, 3, 3, 9'h1AA));
        foreach (spare[k]) cmd(mk(spare[k], 1, 2, 9'h0F0));
        $display("test wiper done");
        cmd(mk(OP_ERASE, 2, 1, 9'h1FF));
        cmd(mk(OP_PROG, 2, 1, 9'h1A5));
        cmd(mk(OP_RDSLOT, 2, 1, 0));
        cmd(mk(OP_LOAD, 2, 1, 0));
        cmd(mk(OP_WRITE, 0, 1, 9'h010));
        cmd(mk(OP_RDWIPER, 0, 1, 0));
        cmd(mk(OP_ERASE, 3, 1, 0));
        cmd(mk(OP_SAVE, 3, 1, 0));
        cmd(mk(OP_RDSLOT, 3, 1, 0));
        cmd(mk(OP_NOP, 0, 0, 0));
        $display("test slots done");
        @(posedge clk);
        wp_n <= 1'b0;
        cmd(mk(OP_ERASE, 2, 1, 0));
        cmd(mk(OP_PROG, 2, 1, 9'h00F));
        cmd(mk(OP_SAVE, 2, 1, 0));
        cmd(mk(OP_RDSLOT, 2, 1, 0));
        cmd(mk(OP_LOAD, 2, 1, 0));
        @(posedge clk);
        wp_n <= 1'b1;
        $display("test protect done");
        cmd(mk(OP_ERASE, 0, 2, 0));
        cmd(mk(OP_PROG, 0, 2, 9'h1C3));
        cmd(mk(OP_SLEEP, 0, 0, 0));
        cmd(mk(OP_UP, 0, 2, 0));
        cmd(mk(OP_RDWIPER, 0, 2, 0));
        cmd(mk(OP_WAKE, 0, 0, 0));
        cmd(mk(OP_RESET, 0, 0, 0));
        cmd(mk(OP_UP, 0, 0, 0));
        cmd(mk(OP_WAKE, 0, 0, 0));
        $display("test power done");
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 4; c++) begin
                cmd(mk(OP_ERASE, 2'(s), 2'(c), 0));
                cmd(mk(OP_PROG, 2'(s), 2'(c), {s[0], 2'(c), 2'(s), 2'(c), 2'(s)}));
            end
        end
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 4; c++) cmd(mk(OP_RDSLOT, 2'(s), 2'(c), 0));
        end
        cmd(mk(OP_NOP, 0, 0, 0));
        $display("test slot map done");
        stop_test();
    end
endmodule
